// File: logic/timer_pkg.sv
// Shared constants, field layouts and carrier types of the timer/counter.
package timer_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TOP     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h18;

  // Interrupt status and mask bit positions.
  localparam int EVT_W       = 3;
  localparam int EVT_OVERFLOW = 0;
  localparam int EVT_COMPARE  = 1;
  localparam int EVT_CAPTURE  = 2;

  // Control register layout, bit 10 down to bit 0.
  localparam int CTRL_W = 11;
  typedef struct packed {
    logic       rst_en;
    logic       wake_en;
    logic       cap_en;
    logic       down;
    logic       run;
    logic [2:0] prescale;
    logic       clk_sel;
    logic [1:0] mode;
  } ctrl_type;

  // Reset values; the top module takes them as its preload defaults.
  localparam logic [CTRL_W-1:0] CTRL_RESET    = 11'h440;
  localparam logic [15:0]       TOP_RESET     = 16'hffff;
  localparam logic [15:0]       COMPARE_RESET = 16'h8000;
  localparam logic [EVT_W-1:0]  MASK_RESET    = 3'h0;

  // Prescaler divide codes: by 1, 8, 64, 256, 1024.
  localparam int PRE_W = 10;
  localparam logic [2:0] PRE_DIV1    = 3'h0;
  localparam logic [2:0] PRE_DIV8    = 3'h1;
  localparam logic [2:0] PRE_DIV64   = 3'h2;
  localparam logic [2:0] PRE_DIV256  = 3'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_WATCHDOG,
    MODE_CLEAR_ON_MATCH,
    MODE_FAST_PWM,
    MODE_PHASE_FREQ_PWM
  } mode_type;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_req_type;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } axi_rsp_type;

endpackage

// File: logic/input_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge output.
`timescale 1ns/10ps
`default_nettype none
module input_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_type;

  sync_state_type s_q;
  sync_state_type s_d;

  // The filtered level only follows once the second and third stages agree.
  always_comb begin
    s_d     = s_q;
    s_d.s1  = pin;
    s_d.s2  = s_q.s1;
    s_d.s3  = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.lvl = s_q.s2;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.lvl;
  assign rise  = !s_q.lvl && s_q.s2 && s_q.s3;

endmodule
`default_nettype wire

// File: logic/hard_timer_counter_pwm.sv
// Hardened 16-bit timer/counter with compare, capture, PWM and AXI4-Lite registers.
// Notes on behaviour
// RULE1: Sixteen-bit counter counting up and down.
// RULE2: Watchdog, clear-on-match, fast PWM, phase-frequency PWM.
// RULE3: Selectable clock source through programmable prescaler.
// RULE4: Overflow, compare and capture raise interrupts.
// RULE5: One interrupt output; overflow flag without host.
// RULE6: Separate wake-up interrupt to standby controller.
// RULE7: Synchronised capture edge stores count, non-PWM; the code captures only while host_attached is high.
// RULE8: Compare match drives the waveform output.
// RULE9: Glitch-free PWM with programmable period.
// RULE10: Host reads and writes registers over bus.
// RULE11: Stand-alone operation from preloaded register values.
// RULE12: Reset pin enable preloaded, honoured always.
// RULE13: Counter reloads from bottom automatically.
// RULE14: Reset pin clears count, flags, output.
`timescale 1ns/10ps
`default_nettype none
module hard_timer_counter_pwm
  import timer_pkg::*;
#(
  parameter int                CNT_W        = 16,
  parameter logic [CTRL_W-1:0] CTRL_INIT    = CTRL_RESET,
  parameter logic [15:0]       TOP_INIT     = TOP_RESET,
  parameter logic [15:0]       COMPARE_INIT = COMPARE_RESET,
  parameter logic [EVT_W-1:0]  MASK_INIT    = MASK_RESET
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire timer_pkg::axi_req_type axi_req,
  output timer_pkg::axi_rsp_type      axi_rsp,
  input  wire logic                  host_attached,
  input  wire logic                  timer_clock_in,
  input  wire logic                  timer_reset_low,
  input  wire logic                  capture_trigger_in,
  output logic [CNT_W-1:0]           count_value,
  output logic                       timer_wave_out,
  output logic                       timer_irq_out,
  output logic                       wake_irq_out
);

  import timer_pkg::*;

  typedef struct packed {
    axi_rsp_type       rsp;
    logic              aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_have;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    ctrl_type          ctrl;
    logic [CNT_W-1:0]  top;
    logic [CNT_W-1:0]  cmp;
    logic [CNT_W-1:0]  top_act;
    logic [CNT_W-1:0]  cmp_act;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  cap;
    logic              dir_down;
    logic [PRE_W-1:0]  pre;
    logic [EVT_W-1:0]  status;
    logic [EVT_W-1:0]  mask;
    logic              wave;
    logic              irq;
    logic              wake;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic clk_rise;
  logic cap_rise;
  logic rst_level;

  input_sync u_clk_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (timer_clock_in),
    .level   (),
    .rise    (clk_rise)
  );

  input_sync u_cap_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (capture_trigger_in),
    .level   (),
    .rise    (cap_rise)
  );

  // The reset pin enters inverted so the cleared synchroniser matches the idle pin.
  input_sync u_rst_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (!timer_reset_low),
    .level   (rst_level),
    .rise    ()
  );

  // Returns {known, data}; unmapped offsets read as zero and are flagged.
  function automatic logic [DATA_W:0] reg_read(input logic [ADDR_W-1:0] a,
                                              input state_type s);
    logic [DATA_W:0] r;
    r = '0;
    r[DATA_W] = 1'b1;
    case (a)
      OFS_CTRL: begin
        r[CTRL_W-1:0] = s.ctrl;
      end
      OFS_TOP: begin
        r[CNT_W-1:0] = s.top;
      end
      OFS_COMPARE: begin
        r[CNT_W-1:0] = s.cmp;
      end
      OFS_COUNT: begin
        r[CNT_W-1:0] = s.cnt;
      end
      OFS_CAPTURE: begin
        r[CNT_W-1:0] = s.cap;
      end
      OFS_STATUS: begin
        r[EVT_W-1:0] = s.status;
      end
      OFS_MASK: begin
        r[EVT_W-1:0] = s.mask;
      end
      default: begin
        r[DATA_W] = 1'b0;
      end
    endcase
    return r;
  endfunction

  logic [DATA_W:0]   wr_old;
  logic [DATA_W:0]   rd_val;
  logic [DATA_W-1:0] bmask;
  logic [DATA_W-1:0] wr_val;
  logic              wr_go;
  logic [EVT_W-1:0]  ev_set;
  logic [EVT_W-1:0]  ev_clr;
  logic              cnt_load;
  logic [CNT_W-1:0]  cnt_load_val;
  logic              pwm;
  logic              tick;
  logic              src_edge;
  logic              rst_pin;
  logic [PRE_W-1:0]  pre_lim;
  logic [CNT_W-1:0]  wrap_end;
  logic [CNT_W-1:0]  nxt;
  mode_type          mode;

  always_comb begin
    s_d          = s_q;
    ev_set       = '0;
    ev_clr       = '0;
    cnt_load     = 1'b0;
    cnt_load_val = '0;
    tick         = 1'b0;
    nxt          = s_q.cnt;
    mode         = mode_type'(s_q.ctrl.mode); // [RULE2]
    pwm          = (mode == MODE_FAST_PWM) || (mode == MODE_PHASE_FREQ_PWM);

    // Write address and data are taken independently, in either order.
    if (axi_req.awvalid && s_q.rsp.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.rsp.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = axi_req.wdata;
      s_d.w_strb = axi_req.wstrb;
    end
    if (s_q.rsp.bvalid && axi_req.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end

    for (int i = 0; i < 4; i++) begin
      bmask[i*8 +: 8] = {8{s_q.w_strb[i]}};
    end
    wr_old = reg_read(s_q.aw_addr, s_q);
    wr_val = (wr_old[DATA_W-1:0] & ~bmask) | (s_q.w_data & bmask);
    wr_go  = s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid;

    if (wr_go) begin // [RULE10]
      s_d.aw_have    = 1'b0;
      s_d.w_have     = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = wr_old[DATA_W] ? RESP_OKAY : RESP_SLVERR;
      case (s_q.aw_addr)
        OFS_CTRL: begin
          s_d.ctrl = ctrl_type'(wr_val[CTRL_W-1:0]);
        end
        OFS_TOP: begin
          s_d.top = wr_val[CNT_W-1:0]; // [RULE9]
        end
        OFS_COMPARE: begin
          s_d.cmp = wr_val[CNT_W-1:0];
        end
        OFS_COUNT: begin
          cnt_load     = 1'b1;
          cnt_load_val = wr_val[CNT_W-1:0];
        end
        OFS_STATUS: begin
          ev_clr = s_q.w_data[EVT_W-1:0] & bmask[EVT_W-1:0];
        end
        OFS_MASK: begin
          s_d.mask = wr_val[EVT_W-1:0];
        end
        default: begin
          s_d.rsp.bresp = RESP_SLVERR;
        end
      endcase
    end

    if (s_q.rsp.rvalid && axi_req.rready) begin
      s_d.rsp.rvalid = 1'b0;
    end
    rd_val = reg_read(axi_req.araddr, s_q);
    if (axi_req.arvalid && s_q.rsp.arready) begin // [RULE10]
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata  = rd_val[DATA_W-1:0];
      s_d.rsp.rresp  = rd_val[DATA_W] ? RESP_OKAY : RESP_SLVERR;
    end

    // Clock source is the system clock or the synchronised pin edge.
    src_edge = s_q.ctrl.clk_sel ? clk_rise : 1'b1; // [RULE3]
    case (s_q.ctrl.prescale)
      PRE_DIV1: begin
        pre_lim = 10'h000;
      end
      PRE_DIV8: begin
        pre_lim = 10'h007;
      end
      PRE_DIV64: begin
        pre_lim = 10'h03f;
      end
      PRE_DIV256: begin
        pre_lim = 10'h0ff;
      end
      default: begin
        pre_lim = 10'h3ff;
      end
    endcase
    if (s_q.ctrl.run && src_edge) begin // [RULE3]
      if (s_q.pre >= pre_lim) begin
        s_d.pre = '0;
        tick    = 1'b1;
      end else begin
        s_d.pre = s_q.pre + 1'b1;
      end
    end

    // Outside PWM the active limits follow the registers at once.
    if (!pwm) begin
      s_d.top_act = s_q.top;
      s_d.cmp_act = s_q.cmp;
    end
    wrap_end = (mode == MODE_CLEAR_ON_MATCH) ? s_q.cmp : s_q.top;

    if (tick) begin
      if (tick && s_q.cnt == s_q.cmp_act) begin
        ev_set[EVT_COMPARE] = 1'b1; // [RULE4]
      end
      case (mode)
        MODE_WATCHDOG, MODE_CLEAR_ON_MATCH: begin
          if (s_q.ctrl.down) begin // [RULE1]
            if (s_q.cnt == '0) begin
              nxt = wrap_end; // [RULE13]
              ev_set[EVT_OVERFLOW] = (mode == MODE_WATCHDOG);
            end else begin
              nxt = s_q.cnt - 1'b1;
            end
          end else if (s_q.cnt == wrap_end) begin
            nxt = '0; // [RULE13]
            ev_set[EVT_OVERFLOW] = (mode == MODE_WATCHDOG);
          end else begin
            nxt = s_q.cnt + 1'b1;
          end
          if (s_q.cnt == s_q.cmp_act) begin
            s_d.wave = !s_q.wave; // [RULE8]
          end
        end
        MODE_FAST_PWM: begin
          if (s_q.cnt >= s_q.top_act) begin
            nxt = '0; // [RULE13]
            ev_set[EVT_OVERFLOW] = 1'b1;
            s_d.top_act = s_q.top; // [RULE9]
            s_d.cmp_act = s_q.cmp;
          end else begin
            nxt = s_q.cnt + 1'b1;
          end
        end
        default: begin
          if (!s_q.dir_down) begin // [RULE1]
            if (s_q.cnt >= s_q.top_act) begin
              s_d.dir_down = (s_q.top_act != '0);
              nxt = (s_q.top_act == '0) ? '0 : s_q.top_act - 1'b1;
            end else begin
              nxt = s_q.cnt + 1'b1;
            end
          end else if (s_q.cnt == '0) begin
            s_d.dir_down = 1'b0; // [RULE13]
            ev_set[EVT_OVERFLOW] = 1'b1;
            s_d.top_act = s_q.top; // [RULE9]
            s_d.cmp_act = s_q.cmp;
            nxt = (s_q.top == '0) ? '0 : {{(CNT_W-1){1'b0}}, 1'b1};
          end else begin
            nxt = s_q.cnt - 1'b1;
          end
        end
      endcase
      // Registered comparison keeps the PWM edge free of glitches.
      if (pwm) begin
        s_d.wave = (nxt < s_d.cmp_act); // [RULE8] [RULE9]
      end
      s_d.cnt = nxt;
    end

    if (!pwm) begin
      s_d.dir_down = 1'b0;
    end

    if (cap_rise && host_attached && s_q.ctrl.cap_en && !pwm) begin
      s_d.cap = s_q.cnt; // [RULE7]
      ev_set[EVT_CAPTURE] = 1'b1; // [RULE4]
    end

    // A bus write of the count wins over a tick in the same cycle.
    if (cnt_load) begin
      s_d.cnt = cnt_load_val;
    end

    // A hardware event in the clearing cycle survives the clear.
    s_d.status = (s_q.status & ~ev_clr) | ev_set; // [RULE4]

    rst_pin = s_q.ctrl.rst_en && rst_level; // [RULE12]
    if (rst_pin) begin // [RULE14]
      s_d.cnt      = '0;
      s_d.pre      = '0;
      s_d.dir_down = 1'b0;
      s_d.status   = '0;
      s_d.wave     = 1'b0;
      s_d.cap      = '0;
    end

    s_d.irq  = host_attached ? |(s_d.status & s_d.mask)
                             : s_d.status[EVT_OVERFLOW]; // [RULE5] [RULE11]
    s_d.wake = s_d.ctrl.wake_en && |s_d.status; // [RULE6]

    s_d.rsp.awready = !s_d.aw_have && !s_d.rsp.bvalid;
    s_d.rsp.wready  = !s_d.w_have && !s_d.rsp.bvalid;
    s_d.rsp.arready = !s_d.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.ctrl    <= ctrl_type'(CTRL_INIT); // [RULE11] [RULE12]
      s_q.top     <= TOP_INIT;
      s_q.cmp     <= COMPARE_INIT;
      s_q.top_act <= TOP_INIT;
      s_q.cmp_act <= COMPARE_INIT;
      s_q.mask    <= MASK_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign axi_rsp        = s_q.rsp;
  assign count_value    = s_q.cnt;
  assign timer_wave_out = s_q.wave;
  assign timer_irq_out  = s_q.irq;
  assign wake_irq_out   = s_q.wake;

endmodule
`default_nettype wire

// File: tb/timer_checker.sv
// Port-level assertions for the timer block.
`timescale 1ns/10ps
`default_nettype none
module timer_checker #(
  parameter int CNT_W = 16
) (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire timer_pkg::axi_req_type axi_req,
  input wire timer_pkg::axi_rsp_type axi_rsp,
  input wire logic                   host_attached,
  input wire logic                   timer_clock_in,
  input wire logic                   timer_reset_low,
  input wire logic                   capture_trigger_in,
  input wire logic [CNT_W-1:0]       count_value,
  input wire logic                   timer_wave_out,
  input wire logic                   timer_irq_out,
  input wire logic                   wake_irq_out
);
  import timer_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  reset_clear_a: assert property (!aresetn |=> count_value == '0 && !timer_wave_out
    && !timer_irq_out && !wake_irq_out) else $error("reset left outputs set");
  pin_reset_a: assert property (disable iff (!aresetn) !timer_reset_low [*6]
    |=> count_value == '0 && !timer_wave_out) else $error("pin reset ignored");
  b_answer_a: assert property (disable iff (!aresetn)
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |=> ##1 axi_rsp.bvalid)
    else $error("write response late");
  b_hold_a: assert property (disable iff (!aresetn) axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write response dropped");
  r_answer_a: assert property (disable iff (!aresetn)
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("read answer late");
  r_hold_a: assert property (disable iff (!aresetn) axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
  aw_block_a: assert property (disable iff (!aresetn) axi_rsp.bvalid
    |-> !axi_rsp.awready && !axi_rsp.wready) else $error("write taken during response");
  ar_block_a: assert property (disable iff (!aresetn) axi_rsp.rvalid
    |-> !axi_rsp.arready) else $error("read taken during answer");
endmodule
bind hard_timer_counter_pwm timer_checker #(.CNT_W(CNT_W)) u_timer_checker (.aclk, .aresetn,
  .axi_req, .axi_rsp, .host_attached, .timer_clock_in, .timer_reset_low, .capture_trigger_in,
  .count_value, .timer_wave_out, .timer_irq_out, .wake_irq_out);
`default_nettype wire

// File: tb/bus_host.sv
// Register-bus host model issuing single reads and writes, promptly or slowly.
`timescale 1ns/10ps
`default_nettype none
module bus_host (
  input  wire logic                   aclk,
  output timer_pkg::axi_req_type      req,
  input  wire timer_pkg::axi_rsp_type rsp
);
  import timer_pkg::*;
  bit slow;
  initial req = '0;
  task automatic give_up();
    tb_top.fail_count++;
    tb_top.complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= !slow;
    do begin
      @(posedge aclk);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while ((req.awvalid && !rsp.awready || req.wvalid && !rsp.wready) && n < 100);
    while (!rsp.bvalid && n < 100) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 100) give_up();
    if (!req.bready) begin
      req.bready <= 1'b1;
      @(posedge aclk);
    end
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= !slow;
    do begin
      @(posedge aclk);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 100);
    if (n >= 100) give_up();
    if (!req.rready) begin
      req.rready <= 1'b1;
      @(posedge aclk);
    end
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the timer block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import timer_pkg::*;
  logic        aclk;
  logic        aresetn;
  axi_req_type axi_req;
  axi_rsp_type axi_rsp;
  logic        host_attached;
  logic        timer_clock_in;
  logic        timer_reset_low;
  logic        capture_trigger_in;
  logic [15:0] count_value;
  logic        timer_wave_out;
  logic        timer_irq_out;
  logic        wake_irq_out;
  int          fail_count;
  int          checks;
  logic [31:0] rd_d;
  logic [1:0]  rs;
  hard_timer_counter_pwm u_hard_timer_counter_pwm (.aclk, .aresetn, .axi_req, .axi_rsp,
    .host_attached, .timer_clock_in, .timer_reset_low, .capture_trigger_in, .count_value,
    .timer_wave_out, .timer_irq_out, .wake_irq_out);
  bus_host u_bus_host (.aclk(aclk), .req(axi_req), .rsp(axi_rsp));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    u_bus_host.wr(a, d, rs);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    u_bus_host.rd(a, rd_d, rs);
    chk("rdata", rd_d, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask
  task automatic t_regs();
    rdc(OFS_CTRL, 32'h440);
    rdc(OFS_TOP, 32'hffff);
    rdc(OFS_COMPARE, 32'h8000);
    rdc(OFS_MASK, 32'h0);
    u_bus_host.slow = 1'b1;
    rdc(8'h1c, 32'h0);
    chk("rresp", 32'(rs), 32'(RESP_SLVERR));
    wrc(8'h1c, 32'h1);
    chk("bresp", 32'(rs), 32'(RESP_SLVERR));
    u_bus_host.slow = 1'b0;
    wrc(OFS_CAPTURE, 32'h55);
    chk("bresp", 32'(rs), 32'(RESP_SLVERR));
    rdc(OFS_CAPTURE, 32'h0);
  endtask
  task automatic t_count();
    logic [15:0] a;
    int n;
    wrc(OFS_CTRL, 32'h400);
    wrc(OFS_TOP, 32'h10);
    wrc(OFS_COUNT, 32'hc);
    wrc(OFS_STATUS, 32'h7);
    cyc(1);
    chk("count", 32'(count_value), 32'hc);
    wrc(OFS_CTRL, 32'h4c0);
    cyc(1);
    a = count_value;
    cyc(1);
    chk("down", 32'(count_value), 32'(a - 16'h1));
    n = 0;
    while (count_value !== 16'h10 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("wrap", 32'(count_value), 32'h10);
    rdc(OFS_STATUS, 32'h1);
    wrc(OFS_CTRL, 32'h448);
    for (int i = 0; i < 2; i++) begin
      cyc(1);
      a = count_value;
      n = 1;
      while (count_value === a && n < 20) begin
        cyc(1);
        n++;
      end
    end
    chk("prescale", 32'(n), 32'd8);
    wrc(OFS_CTRL, 32'h444);
    wrc(OFS_COUNT, 32'h0);
    repeat (5) begin
      @(posedge aclk);
      timer_clock_in <= 1'b1;
      repeat (4) @(posedge aclk);
      timer_clock_in <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    cyc(6);
    chk("pin count", 32'(count_value), 32'h5);
  endtask
  task automatic t_irq();
    int n;
    wrc(OFS_CTRL, 32'h400);
    wrc(OFS_STATUS, 32'h7);
    wrc(OFS_MASK, 32'h1);
    cyc(2);
    chk("irq", 32'(timer_irq_out), 32'h0);
    wrc(OFS_COUNT, 32'h10);
    wrc(OFS_CTRL, 32'h440);
    n = 0;
    while (timer_irq_out !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk("irq", 32'(timer_irq_out), 32'h1);
    wrc(OFS_CTRL, 32'h600);
    cyc(2);
    chk("wake", 32'(wake_irq_out), 32'h1);
    wrc(OFS_MASK, 32'h0);
    cyc(2);
    chk("irq", 32'(timer_irq_out), 32'h0);
    @(posedge aclk);
    host_attached <= 1'b0;
    cyc(3);
    chk("irq", 32'(timer_irq_out), 32'h1);
    wrc(OFS_STATUS, 32'h1);
    cyc(2);
    chk("irq", 32'(timer_irq_out), 32'h0);
    chk("wake", 32'(wake_irq_out), 32'h0);
    @(posedge aclk);
    host_attached <= 1'b1;
  endtask
  task automatic t_modes();
    logic [15:0] mx;
    logic        pw;
    int          tg;
    wrc(OFS_STATUS, 32'h7);
    wrc(OFS_COMPARE, 32'h3);
    wrc(OFS_COUNT, 32'h0);
    wrc(OFS_CTRL, 32'h441);
    cyc(2);
    mx = 16'h0;
    tg = 0;
    pw = timer_wave_out;
    repeat (28) begin
      cyc(1);
      if (count_value > mx) mx = count_value;
      if (timer_wave_out !== pw) tg++;
      pw = timer_wave_out;
    end
    chk("match end", 32'(mx), 32'h3);
    chk("toggles", 32'(tg), 32'd7);
    rdc(OFS_STATUS, 32'h2);
    wrc(OFS_TOP, 32'h9);
    for (int m = 2; m < 4; m++) begin
      wrc(OFS_CTRL, 32'h440 | 32'(m));
      cyc(40);
      tg = 0;
      // Whole periods only: fast PWM repeats every 10 cycles, dual-slope every 18.
      repeat ((m == 2) ? 30 : 36) begin
        cyc(1);
        if (timer_wave_out === 1'b1) tg++;
      end
      chk("pwm high", 32'(tg), (m == 2) ? 32'd9 : 32'd10);
    end
  endtask
  task automatic t_cap();
    wrc(OFS_CTRL, 32'h500);
    wrc(OFS_COUNT, 32'h1234);
    wrc(OFS_STATUS, 32'h7);
    @(posedge aclk);
    capture_trigger_in <= 1'b1;
    repeat (4) @(posedge aclk);
    capture_trigger_in <= 1'b0;
    cyc(8);
    rdc(OFS_CAPTURE, 32'h1234);
    rdc(OFS_STATUS, 32'h4);
  endtask
  task automatic t_pin();
    wrc(OFS_CTRL, 32'h440);
    cyc(3);
    @(posedge aclk);
    timer_reset_low <= 1'b0;
    cyc(8);
    chk("count", 32'(count_value), 32'h0);
    chk("wave", 32'(timer_wave_out), 32'h0);
    rdc(OFS_CTRL, 32'h440);
    @(posedge aclk);
    timer_reset_low <= 1'b1;
  endtask
  initial begin
    aresetn = 1'b0;
    host_attached = 1'b1;
    timer_clock_in = 1'b0;
    timer_reset_low = 1'b1;
    capture_trigger_in = 1'b0;
    fail_count = 0;
    checks = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_regs();
    t_count();
    t_irq();
    t_modes();
    t_cap();
    t_pin();
    complete_run();
  end
endmodule
`default_nettype wire
